// ---- scs_defines.svh ----
// Offsets, field positions, reset values and counts of the SDRAM command sequencer
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_CFG_OFS 4'h0
`define SCS_STAT_OFS 4'h4
`define SCS_RCD_LSB 0
`define SCS_WR_LSB 3
`define SCS_RP_LSB 5
`define SCS_RC_LSB 8
`define SCS_CL3_BIT 11
`define SCS_RATE2X_BIT 12
`define SCS_NIBBLE_BIT 13
`define SCS_CFG_MASK 32'h0000_3fff
`define SCS_CFG_RESET 32'h0000_0121
`define SCS_INIT_REFRESHES 4'h8
`define SCS_SUSP_1X 3'h1
`define SCS_SUSP_2X 3'h2
`endif

// ---- scs_pkg.sv ----
// Types of the SDRAM command sequencer
`default_nettype none
package scs_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_INIT_PRE = 4'b0001,
		ST_INIT_REF = 4'b0010,
		ST_INIT_MRS = 4'b0011,
		ST_ACT = 4'b0100,
		ST_COL = 4'b0101,
		ST_CAS_NOP = 4'b0110,
		ST_SUSP = 4'b0111,
		ST_CAPT = 4'b1000,
		ST_WREC = 4'b1001,
		ST_PRE = 4'b1010,
		ST_WAIT = 4'b1011
	} scs_state_t;
	// {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		CMD_MRS = 4'b0000,
		CMD_REF = 4'b0001,
		CMD_PRE = 4'b0010,
		CMD_ACT = 4'b0011,
		CMD_WRITE = 4'b0100,
		CMD_READ = 4'b0101,
		CMD_NOP = 4'b0111
	} scs_cmd_t;
endpackage
`default_nettype wire

// ---- scs_sdram_sequencer.sv ----
// SDRAM command sequencer: init, reads, writes, bursts, 8/4-bit data
//
// Added by the designer: the placing of the registers and the strobed register port.
`include "scs_defines.svh"
`default_nettype none
module scs_sdram_sequencer (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqWrite,
	input wire logic [21:0] reqAddr,
	input wire logic [4:0] reqLen,
	input wire logic [7:0] wrData,
	output logic wrTake,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic sdramClk,
	output logic sdramCke,
	output logic [3:0] sdramCmd,
	output logic [11:0] sdramAddr,
	output logic [1:0] sdramBank,
	input wire logic [7:0] dqIn,
	output logic [7:0] dqOut,
	output logic dqOe
);
	// ********************************
	// Register port
	// ********************************
	logic [31:0] cfg_reg, cfg_next;
	logic [31:0] rdata_reg, rdata_next;
	logic initDone_reg, initDone_next;
	scs_pkg::scs_state_t state_reg, state_next;

	function automatic logic [2:0] field3(input logic [31:0] c, input int lsb);
		field3 = c[lsb +: 3];
	endfunction

	always_comb begin
		cfg_next = cfg_reg;
		rdata_next = 32'h0000_0000;
		if (regWrite && regAddr == `SCS_CFG_OFS) begin
			cfg_next = regWdata & `SCS_CFG_MASK;
		end
		if (regRead) begin
			case (regAddr)
				`SCS_CFG_OFS: rdata_next = cfg_reg;
				`SCS_STAT_OFS: rdata_next = {26'h0, state_reg, (state_reg != scs_pkg::ST_IDLE),
					initDone_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= `SCS_CFG_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
		end
	end
	assign regRdata = rdata_reg;

	logic [2:0] rcd, rp3, rc;
	logic [1:0] wrd;
	logic cl3, rate2x, nibble;
	always_comb begin
		rcd = field3(cfg_reg, `SCS_RCD_LSB);
		rp3 = field3(cfg_reg, `SCS_RP_LSB);
		rc = field3(cfg_reg, `SCS_RC_LSB);
		wrd = cfg_reg[`SCS_WR_LSB +: 2];
		cl3 = cfg_reg[`SCS_CL3_BIT];
		rate2x = cfg_reg[`SCS_RATE2X_BIT];
		nibble = cfg_reg[`SCS_NIBBLE_BIT];
	end

	// ********************************
	// Data pin synchroniser
	// ********************************
	logic [7:0] dqMeta_reg, dqSync_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dqMeta_reg <= 8'h00;
			dqSync_reg <= 8'h00;
		end else begin
			dqMeta_reg <= dqIn;
			dqSync_reg <= dqMeta_reg;
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	// Commands change as the SDRAM clock falls, so the chip samples them mid-cycle
	logic phase_reg, phase_next;
	logic sclk_reg, sclk_next;
	logic cke_reg, cke_next;
	scs_pkg::scs_state_t ret_reg, ret_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [3:0] refs_reg, refs_next;
	logic isWrite_reg, isWrite_next;
	logic [21:0] addr_reg, addr_next;
	logic [4:0] len_reg, len_next;
	logic half_reg, half_next;
	logic [3:0] cmd_reg, cmd_next;
	logic [11:0] sa_reg, sa_next;
	logic [1:0] ba_reg, ba_next;
	logic [7:0] dqo_reg, dqo_next;
	logic dqOe_reg, dqOe_next;
	logic [7:0] rd_reg, rd_next;
	logic rdv_reg, rdv_next;
	logic take_reg, take_next;
	logic tick, accept, unitLast, pageEnd;
	logic [7:0] colAddr;

	always_comb begin
		tick = phase_reg;
		reqReady = (state_reg == scs_pkg::ST_IDLE) && initDone_reg && tick;
		accept = reqValid && reqReady && (reqLen != 5'h00);
		unitLast = !nibble || half_reg;
		pageEnd = nibble ? ((&addr_reg[6:0]) && half_reg) : (&addr_reg[7:0]);
		colAddr = nibble ? {addr_reg[6:0], half_reg} : addr_reg[7:0];
	end

	always_comb begin
		phase_next = !phase_reg;
		state_next = state_reg;
		ret_next = ret_reg;
		cnt_next = cnt_reg;
		refs_next = refs_reg;
		initDone_next = initDone_reg;
		isWrite_next = isWrite_reg;
		addr_next = addr_reg;
		len_next = len_reg;
		half_next = half_reg;
		cmd_next = cmd_reg;
		sa_next = sa_reg;
		ba_next = ba_reg;
		dqo_next = dqo_reg;
		dqOe_next = dqOe_reg;
		rd_next = rd_reg;
		rdv_next = 1'b0;
		take_next = 1'b0;
		cke_next = cke_reg;
		if (tick) begin
			cmd_next = scs_pkg::CMD_NOP;
			dqOe_next = 1'b0;
			cke_next = 1'b1;
			case (state_reg)
				scs_pkg::ST_IDLE: begin
					if (accept) begin
						isWrite_next = reqWrite;
						addr_next = reqAddr;
						len_next = reqLen;
						half_next = 1'b0;
						state_next = scs_pkg::ST_ACT;
					end
				end
				scs_pkg::ST_INIT_PRE: begin
					cmd_next = scs_pkg::CMD_PRE;
					sa_next = 12'h400;
					refs_next = `SCS_INIT_REFRESHES;
					cnt_next = rp3;
					ret_next = scs_pkg::ST_INIT_REF;
					state_next = (rp3 == 3'h0) ? scs_pkg::ST_INIT_REF : scs_pkg::ST_WAIT;
				end
				scs_pkg::ST_INIT_REF: begin
					cmd_next = scs_pkg::CMD_REF;
					refs_next = refs_reg - 4'h1;
					ret_next = (refs_reg == 4'h1) ? scs_pkg::ST_INIT_MRS : scs_pkg::ST_INIT_REF;
					cnt_next = rc;
					state_next = (rc == 3'h0) ? ret_next : scs_pkg::ST_WAIT;
				end
				scs_pkg::ST_INIT_MRS: begin
					cmd_next = scs_pkg::CMD_MRS;
					sa_next = {5'h00, cl3 ? 3'h3 : 3'h2, 4'h0};
					initDone_next = 1'b1;
					state_next = scs_pkg::ST_IDLE;
				end
				scs_pkg::ST_ACT: begin
					cmd_next = scs_pkg::CMD_ACT;
					// Half-width data halves the page, so the row starts one bit lower
					sa_next = nibble ? addr_reg[18:7] : addr_reg[19:8];
					ba_next = addr_reg[21:20];
					cnt_next = rcd;
					ret_next = scs_pkg::ST_COL;
					state_next = (rcd == 3'h0) ? scs_pkg::ST_COL : scs_pkg::ST_WAIT;
				end
				scs_pkg::ST_COL: begin
					cmd_next = isWrite_reg ? scs_pkg::CMD_WRITE : scs_pkg::CMD_READ;
					sa_next = {4'h0, colAddr};
					if (isWrite_reg) begin
						dqOe_next = 1'b1;
						// Low nibble first in four-bit mode
						dqo_next = !nibble ? wrData :
							(half_reg ? {4'h0, wrData[7:4]} : {4'h0, wrData[3:0]});
						take_next = unitLast;
						state_next = scs_pkg::ST_CAPT;
					end else begin
						state_next = cl3 ? scs_pkg::ST_CAS_NOP : scs_pkg::ST_SUSP;
						cnt_next = rate2x ? `SCS_SUSP_2X : `SCS_SUSP_1X;
					end
				end
				scs_pkg::ST_CAS_NOP: begin
					state_next = scs_pkg::ST_SUSP;
					cnt_next = rate2x ? `SCS_SUSP_2X : `SCS_SUSP_1X;
				end
				scs_pkg::ST_SUSP: begin
					cke_next = 1'b0;
					cnt_next = cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_next = scs_pkg::ST_CAPT;
					end
				end
				scs_pkg::ST_CAPT: begin
					if (!isWrite_reg) begin
						if (nibble && !half_reg) begin
							rd_next = {4'h0, dqSync_reg[3:0]};
						end else begin
							rd_next = nibble ? {dqSync_reg[3:0], rd_reg[3:0]} : dqSync_reg;
							rdv_next = 1'b1;
						end
					end
					half_next = nibble && !half_reg;
					if (unitLast) begin
						addr_next = addr_reg + 22'h1;
						len_next = len_reg - 5'h1;
					end
					if ((unitLast && len_reg == 5'h1) || pageEnd) begin
						state_next = scs_pkg::ST_WREC;
						cnt_next = {1'b0, wrd} + 3'h1;
					end else begin
						state_next = scs_pkg::ST_COL;
					end
				end
				scs_pkg::ST_WREC: begin
					cnt_next = cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_next = scs_pkg::ST_PRE;
					end
				end
				scs_pkg::ST_PRE: begin
					cmd_next = scs_pkg::CMD_PRE;
					sa_next = 12'h400;
					// More bytes left means a page crossing: reopen the next row
					ret_next = (len_reg != 5'h0) ? scs_pkg::ST_ACT : scs_pkg::ST_IDLE;
					cnt_next = {1'b0, rp3[1:0]};
					state_next = (rp3[1:0] == 2'h0) ? ret_next : scs_pkg::ST_WAIT;
				end
				scs_pkg::ST_WAIT: begin
					cnt_next = cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_next = ret_reg;
					end
				end
				default: state_next = scs_pkg::ST_IDLE;
			endcase
		end
		// Stops only after the read command is clocked in; data then lands on a rising edge
		sclk_next = !phase_reg && cke_next;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= 1'b0;
			sclk_reg <= 1'b0;
			cke_reg <= 1'b1;
			state_reg <= scs_pkg::ST_INIT_PRE;
			ret_reg <= scs_pkg::ST_IDLE;
			cnt_reg <= 3'h0;
			refs_reg <= 4'h0;
			initDone_reg <= 1'b0;
			isWrite_reg <= 1'b0;
			addr_reg <= 22'h0;
			len_reg <= 5'h0;
			half_reg <= 1'b0;
			cmd_reg <= scs_pkg::CMD_NOP;
			sa_reg <= 12'h000;
			ba_reg <= 2'h0;
			dqo_reg <= 8'h00;
			dqOe_reg <= 1'b0;
			rd_reg <= 8'h00;
			rdv_reg <= 1'b0;
			take_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			sclk_reg <= sclk_next;
			cke_reg <= cke_next;
			state_reg <= state_next;
			ret_reg <= ret_next;
			cnt_reg <= cnt_next;
			refs_reg <= refs_next;
			initDone_reg <= initDone_next;
			isWrite_reg <= isWrite_next;
			addr_reg <= addr_next;
			len_reg <= len_next;
			half_reg <= half_next;
			cmd_reg <= cmd_next;
			sa_reg <= sa_next;
			ba_reg <= ba_next;
			dqo_reg <= dqo_next;
			dqOe_reg <= dqOe_next;
			rd_reg <= rd_next;
			rdv_reg <= rdv_next;
			take_reg <= take_next;
		end
	end

	assign sdramClk = sclk_reg;
	assign sdramCke = cke_reg;
	assign sdramCmd = cmd_reg;
	assign sdramAddr = sa_reg;
	assign sdramBank = ba_reg;
	assign dqOut = dqo_reg;
	assign dqOe = dqOe_reg;
	assign rdData = rd_reg;
	assign rdValid = rdv_reg;
	assign wrTake = take_reg;
endmodule
`default_nettype wire

// ---- scs_seq_assertions.sv ----
// Concurrent checks on the SDRAM command sequencer ports
`default_nettype none
module scs_seq_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic reqReady,
	input wire logic sdramClk,
	input wire logic sdramCke,
	input wire logic [3:0] sdramCmd,
	input wire logic [11:0] sdramAddr,
	input wire logic dqOe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Config shadow and command history
	// ****
	logic [13:0] cfg_reg, cfg_next;
	logic [7:0] nop_reg, nop_next;
	logic [3:0] last_reg, last_next, prev_reg, ref_reg, ref_next;
	logic start;
	assign start = sdramCmd != prev_reg && sdramCmd != scs_pkg::CMD_NOP;
	always_comb begin
		cfg_next = (regWrite && regAddr == 4'h0) ? regWdata[13:0] : cfg_reg;
		// Saturates so long idle spells never wrap
		nop_next = sdramCmd != scs_pkg::CMD_NOP ? 8'h00 : nop_reg + {7'h0, nop_reg != 8'hff};
		last_next = start ? sdramCmd : last_reg;
		ref_next = ref_reg + {3'h0, start && sdramCmd == scs_pkg::CMD_REF};
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg <= 14'h0121;
			nop_reg <= 8'h00;
			last_reg <= scs_pkg::CMD_NOP;
			prev_reg <= scs_pkg::CMD_NOP;
			ref_reg <= 4'h0;
		end else begin
			cfg_reg <= cfg_next;
			nop_reg <= nop_next;
			last_reg <= last_next;
			prev_reg <= sdramCmd;
			ref_reg <= ref_next;
		end
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_new(logic [3:0] c);
		start && sdramCmd == c;
	endsequence
	sequence s_after(logic [3:0] c, logic [3:0] p);
		s_new(c) ##0 last_reg == p;
	endsequence
	a_init_precharge: assert property (
		s_after(scs_pkg::CMD_REF, scs_pkg::CMD_PRE) |-> nop_reg == {4'h0, cfg_reg[7:5], 1'b0})
		else $error("init precharge gap wrong");
	a_eight_refresh: assert property (s_new(scs_pkg::CMD_MRS) |-> ref_reg == 4'h8)
		else $error("mode set before eight refreshes");
	a_no_extra_refresh: assert property (s_new(scs_pkg::CMD_REF) |-> ref_reg < 4'h8)
		else $error("refresh beyond eight");
	a_ready_after_init: assert property (reqReady |-> ref_reg == 4'h8)
		else $error("ready before init");
	a_refresh_gap: assert property (
		start && last_reg == scs_pkg::CMD_REF |-> nop_reg == {4'h0, cfg_reg[10:8], 1'b0})
		else $error("refresh gap wrong");
	a_row_to_column: assert property (
		start && last_reg == scs_pkg::CMD_ACT
		&& (sdramCmd == scs_pkg::CMD_WRITE || sdramCmd == scs_pkg::CMD_READ)
		|-> nop_reg == {4'h0, cfg_reg[2:0], 1'b0})
		else $error("activate to column gap wrong");
	a_drive_with_write: assert property (dqOe == (sdramCmd == scs_pkg::CMD_WRITE))
		else $error("data drive not matched to write");
	a_write_recovery: assert property (
		s_after(scs_pkg::CMD_PRE, scs_pkg::CMD_WRITE)
		|-> nop_reg == {4'h0, {1'b0, cfg_reg[4:3]} + 3'h2, 1'b0})
		else $error("write recovery gap wrong");
	a_precharge_gap: assert property (
		start && last_reg == scs_pkg::CMD_PRE && ref_reg == 4'h8
		|-> nop_reg >= {5'h0, cfg_reg[6:5], 1'b0})
		else $error("precharge gap too short");
	a_precharge_all: assert property (s_new(scs_pkg::CMD_PRE) |-> sdramAddr[10])
		else $error("precharge not all banks");
	a_column_latency: assert property (
		$fell(sdramCke) |-> last_reg == scs_pkg::CMD_READ && nop_reg == {6'h0, cfg_reg[11], 1'b0})
		else $error("latency nop wrong");
	a_suspend_1x: assert property (
		$fell(sdramCke) && !cfg_reg[12] |-> (!sdramCke && !sdramClk)[*2] ##1 sdramCke)
		else $error("suspend length wrong at 1x");
	a_suspend_2x: assert property (
		$fell(sdramCke) && cfg_reg[12] |-> (!sdramCke && !sdramClk)[*4] ##1 sdramCke)
		else $error("suspend length wrong at 2x");
endmodule
bind scs_sdram_sequencer scs_seq_assertions chk (.clk, .rstn, .regAddr, .regWdata, .regWrite,
	.reqReady, .sdramClk, .sdramCke, .sdramCmd, .sdramAddr, .dqOe);
`default_nettype wire

// ---- scs_sdram_model.sv ----
// Behavioural SDRAM chip at the sequencer's far side
`default_nettype none
module scs_sdram_model (
	input wire logic sdramClk,
	input wire logic sdramCke,
	input wire logic [3:0] sdramCmd,
	input wire logic [11:0] sdramAddr,
	input wire logic [1:0] sdramBank,
	input wire logic [7:0] dqOut,
	output logic [7:0] dqIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [25:0]];
	logic [11:0] row [4];
	logic [25:0] key;
	assign key = {sdramBank, row[sdramBank], sdramAddr};
	initial dqIn = 8'h00;
	always @(posedge sdramClk) begin
		if (sdramCke) begin
			case (sdramCmd)
				scs_pkg::CMD_ACT: row[sdramBank] <= sdramAddr;
				scs_pkg::CMD_WRITE: mem[key] = dqOut;
				scs_pkg::CMD_READ: dqIn <= mem.exists(key) ? mem[key] : ~key[7:0];
				scs_pkg::CMD_NOP: ;
				// Released bus must not keep showing the last byte
				default: dqIn <= ~dqIn;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb_scs.sv ----
// Self-checking bench for the SDRAM command sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic reqValid = 1'b0, reqWrite = 1'b0, reqReady, wrTake, rdValid, sdramClk, sdramCke, dqOe;
	logic [3:0] regAddr = 4'h0, sdramCmd;
	logic [31:0] regWdata = 32'h0, regRdata, rv;
	logic [21:0] reqAddr = 22'h0;
	logic [4:0] reqLen = 5'h1;
	logic [7:0] wrData = 8'h00, rdData, dqIn, dqOut;
	logic [11:0] sdramAddr;
	logic [1:0] sdramBank;
	int errors = 0, tests_run = 0;
	always #2.5 clk = ~clk;
	scs_sdram_sequencer uut (.clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.reqValid, .reqReady, .reqWrite, .reqAddr, .reqLen, .wrData, .wrTake, .rdData, .rdValid,
		.sdramClk, .sdramCke, .sdramCmd, .sdramAddr, .sdramBank, .dqIn, .dqOut, .dqOe);
	scs_sdram_model chip (.sdramClk, .sdramCke, .sdramCmd, .sdramAddr, .sdramBank, .dqOut, .dqIn);
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic regWr(input logic [31:0] d);
		@(posedge clk);
		regAddr <= 4'h0;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic regRd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		rv = regRdata;
	endtask
	task automatic waitReady();
		int t;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (reqReady !== 1'b1 && t < 2000);
		chk({31'h0, reqReady}, 32'h1);
		@(posedge clk);
	endtask
	function automatic logic [7:0] pat(input logic [21:0] a, input int i);
		return a[7:0] + 8'(i) ^ 8'h5a;
	endfunction
	task automatic xfer(input logic w, input logic [21:0] a, input logic [4:0] n);
		int k;
		k = 0;
		@(posedge clk);
		reqWrite <= w;
		reqAddr <= a;
		reqLen <= n;
		wrData <= pat(a, 0);
		reqValid <= 1'b1;
		waitReady();
		reqValid <= 1'b0;
		for (int t = 0; k < n && t < 3000; t++) begin
			@(negedge clk);
			if (w && wrTake === 1'b1 || !w && rdValid === 1'b1) begin
				if (!w)
					chk({24'h0, rdData}, {24'h0, pat(a, k)});
				k++;
				@(posedge clk);
				wrData <= pat(a, k);
			end
		end
		chk(32'(k), {27'h0, n});
		waitReady();
	endtask
	task automatic loopBack(input logic [21:0] a, input logic [4:0] n);
		xfer(1'b1, a, n);
		xfer(1'b0, a, n);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic tInit();
		waitReady();
		regRd(4'h4);
		chk(rv & 32'h1, 32'h1);
		regRd(4'h0);
		chk(rv, 32'h0000_0121);
		regRd(4'h8);
		chk(rv, 32'h0);
	endtask
	task automatic tSingle();
		loopBack(22'h012345, 5'h01);
	endtask
	task automatic tTimings();
		regWr(32'h0000_1a5b);
		loopBack(22'h2a1f10, 5'h05);
		regWr(32'h0000_0020);
		loopBack(22'h100001, 5'h02);
	endtask
	task automatic tPage();
		regWr(32'h0000_0121);
		loopBack(22'h3040fd, 5'h06);
	endtask
	task automatic tNibble();
		regWr(32'h0000_2121);
		loopBack(22'h05077e, 5'h03);
	endtask
	task automatic results();
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		tInit();
		tSingle();
		tTimings();
		tPage();
		tNibble();
		results();
	end
	// Whole run needs under a thousand cycles
	initial begin
		#200000;
		errors++;
		results();
	end
endmodule
`default_nettype wire
